//--- src/mpsc_pkg.sv
// Purpose: Shared types and constants for the module power-state controller
// Assumes: Single clock domain at 40 MHz, active-low asynchronous reset
// Notes: Synchronised pin vector layout and status word live here

package mpsc_pkg;

  // ----------------------------------------------------------------
  // Controller states (Gray along run -> enter -> standby -> lost)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN      = 3'h0,
    ST_SR_ENTER = 3'h1,
    ST_STANDBY  = 3'h3,
    ST_LOST     = 3'h2,
    ST_SUSPEND  = 3'h4
  } mpsc_state_t;

  // ----------------------------------------------------------------
  // Processor native modes and board-level states
  // ----------------------------------------------------------------
  localparam logic [1:0] CPU_RUN = 2'h0;
  localparam logic [1:0] CPU_WAIT = 2'h1;
  localparam logic [1:0] CPU_DOZE = 2'h2;
  localparam logic [1:0] CPU_STOP = 2'h3;

  localparam logic [1:0] BOARD_RUN = 2'h0;
  localparam logic [1:0] BOARD_SUSPEND = 2'h1;
  localparam logic [1:0] BOARD_STANDBY = 2'h2;

  localparam logic [1:0] OSC_ALL_ON = 2'h3;
  localparam logic [1:0] OSC_MAIN_ONLY = 2'h1;
  localparam logic [1:0] OSC_ALL_OFF = 2'h0;

  // ----------------------------------------------------------------
  // Pin inputs passed through the synchroniser
  // ----------------------------------------------------------------
  localparam int PIN_W = 4;
  localparam int PIN_RST = 0;
  localparam int PIN_LIGHT = 1;
  localparam int PIN_DEEP = 2;
  localparam int PIN_SUPPLY = 3;
  localparam logic [PIN_W-1:0] PIN_IDLE = 4'hf;

  localparam int IRQ_W = 8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic suspend;
    logic standby;
    logic [1:0] suspend_mode;
  } mpsc_sw_req_t;

  typedef struct packed {
    logic [1:0] board_state;
    logic [1:0] cpu_mode;
    logic [1:0] osc_en;
    logic core_clk_en;
    logic periph_clk_en;
    logic supplies_active;
    logic self_refresh_req;
    logic context_lost;
  } mpsc_status_t;

  localparam mpsc_status_t STATUS_RESET = '{
    board_state: BOARD_RUN, cpu_mode: CPU_RUN, osc_en: OSC_ALL_ON,
    core_clk_en: 1'b1, periph_clk_en: 1'b1, supplies_active: 1'b1,
    self_refresh_req: 1'b0, context_lost: 1'b0};

  // Suspend accepts only a low-power mode; a run code falls back to wait
  function automatic logic [1:0] suspend_mode_of(input logic [1:0] sel);
    suspend_mode_of = (sel == CPU_RUN) ? CPU_WAIT : sel;
  endfunction : suspend_mode_of

endpackage : mpsc_pkg

//--- src/mpsc_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin inputs
// Assumes: Pins idle at PIN_IDLE, clock enable freezes both stages
// Notes: The first stage feeds only the second stage
`timescale 1ns/1ps

module mpsc_sync (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic [mpsc_pkg::PIN_W-1:0] pins_i,
  output logic [mpsc_pkg::PIN_W-1:0] pins_o
);
  import mpsc_pkg::*;

  logic [PIN_W-1:0] meta_r;
  logic [PIN_W-1:0] meta_nxt;
  logic [PIN_W-1:0] sync_r;
  logic [PIN_W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    if (clk_en_i) begin
      meta_nxt = pins_i;
      sync_nxt = meta_r;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= PIN_IDLE;
      sync_r <= PIN_IDLE;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign pins_o = sync_r;

endmodule : mpsc_sync

//--- src/mpsc_outreg.sv
// Purpose: Registered clock, mode and supply outputs decoded from the state
// Assumes: Inputs come from the controller on the same clock
// Notes: Every output is a flip-flop; the core reset stays low through reset
`timescale 1ns/1ps

module mpsc_outreg (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire mpsc_pkg::mpsc_state_t state_i,
  input wire logic [1:0] suspend_mode_i,
  input wire logic supply_good_i,
  input wire logic reset_line_n_i,
  output mpsc_pkg::mpsc_status_t status_o,
  output logic module_reset_n_o
);
  import mpsc_pkg::*;

  mpsc_status_t status_r;
  mpsc_status_t status_nxt;
  logic mrst_r;
  logic mrst_nxt;

  always_comb begin
    status_nxt = status_r;
    mrst_nxt = mrst_r;
    if (clk_en_i) begin
      status_nxt = STATUS_RESET;
      unique case (state_i)
        ST_RUN: begin
          status_nxt = STATUS_RESET;
        end
        ST_SUSPEND: begin
          status_nxt.board_state = BOARD_SUSPEND;
          status_nxt.cpu_mode = suspend_mode_i;
          status_nxt.core_clk_en = 1'b0;
          status_nxt.periph_clk_en = (suspend_mode_i == CPU_WAIT);
          status_nxt.osc_en = (suspend_mode_i == CPU_STOP) ? OSC_MAIN_ONLY : OSC_ALL_ON;
          status_nxt.supplies_active = 1'b1;
        end
        ST_SR_ENTER: begin
          status_nxt.self_refresh_req = 1'b1;
        end
        ST_STANDBY, ST_LOST: begin
          status_nxt.board_state = BOARD_STANDBY;
          status_nxt.cpu_mode = CPU_STOP;
          status_nxt.osc_en = OSC_ALL_OFF;
          status_nxt.core_clk_en = 1'b0;
          status_nxt.periph_clk_en = 1'b0;
          status_nxt.supplies_active = supply_good_i;
          status_nxt.self_refresh_req = 1'b1;
          status_nxt.context_lost = (state_i == ST_LOST);
        end
        default: begin
          status_nxt = STATUS_RESET;
        end
      endcase
      // Core follows the reset line with no stretch; lost context forces reboot
      mrst_nxt = reset_line_n_i && (state_i != ST_LOST);
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_r <= STATUS_RESET;
      mrst_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mrst_r <= mrst_nxt;
    end
  end

  assign status_o = status_r;
  assign module_reset_n_o = mrst_r;

endmodule : mpsc_outreg

//--- src/mpsc_ctrl.sv
// What this block does
// - Three board states run, suspend, standby map onto four processor modes.
// - In run, both oscillators and every derived clock stay enabled.
// - In run, all supply domains are reported and treated active.
// - Run may be entered directly from any other state.
// - In standby, any valid wake event returns to run.
// - Reset line low or any enabled pending interrupt is a wake event.
// - Suspend entered on light-sleep request falling edge or software request.
// - Entering suspend puts the processor into stop, wait or doze.
// - During suspend supplies stay active and context is preserved.
// - In suspend, internal or external wake event returns to run.
// - Standby entered on deep-sleep request falling edge or software request.
// - Entering standby puts the processor into stop mode.
// - In standby every clock is halted.
// - Main supply lost in standby forces full reboot, not a wake.
// - Standby wakes to run only while main supply stayed powered.
// - Memory placed into self-refresh before standby is entered.
// - Reset line low holds core reset until released, no added delay.
//
// Purpose: Board-level power-state controller on the module clock
// Assumes: Interrupt and software inputs are on sys_clk_i; pins are not
// Notes: Wake events take priority over new sleep requests
`timescale 1ns/1ps

module mpsc_ctrl (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic system_reset_line_n_i,
  input wire logic light_sleep_request_n_i,
  input wire logic deep_sleep_request_n_i,
  input wire logic main_supply_good_i,
  input wire logic [mpsc_pkg::IRQ_W-1:0] irq_pending_i,
  input wire logic [mpsc_pkg::IRQ_W-1:0] irq_enable_i,
  input wire mpsc_pkg::mpsc_sw_req_t sw_req_i,
  input wire logic self_refresh_ack_i,
  output mpsc_pkg::mpsc_status_t status_o,
  output logic module_reset_n_o
);
  import mpsc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins_s;
  logic rst_line_s;
  logic light_s;
  logic deep_s;
  logic supply_s;

  mpsc_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .pins_i({main_supply_good_i, deep_sleep_request_n_i,
             light_sleep_request_n_i, system_reset_line_n_i}),
    .pins_o(pins_s)
  );

  assign rst_line_s = pins_s[PIN_RST];
  assign light_s = pins_s[PIN_LIGHT];
  assign deep_s = pins_s[PIN_DEEP];
  assign supply_s = pins_s[PIN_SUPPLY];

  logic light_prev_r;
  logic light_prev_nxt;
  logic deep_prev_r;
  logic deep_prev_nxt;

  always_comb begin
    light_prev_nxt = light_prev_r;
    deep_prev_nxt = deep_prev_r;
    if (clk_en_i) begin
      light_prev_nxt = light_s;
      deep_prev_nxt = deep_s;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      light_prev_r <= 1'b1;
      deep_prev_r <= 1'b1;
    end else begin
      light_prev_r <= light_prev_nxt;
      deep_prev_r <= deep_prev_nxt;
    end
  end

  logic light_fall;
  logic deep_fall;
  logic light_go;
  logic deep_go;
  logic wake;

  assign light_fall = light_prev_r && !light_s;
  assign deep_fall = deep_prev_r && !deep_s;
  assign light_go = light_fall || sw_req_i.suspend;
  assign deep_go = deep_fall || sw_req_i.standby;
  assign wake = !rst_line_s || (|(irq_pending_i & irq_enable_i));

  // ----------------------------------------------------------------
  // Power-state machine
  // ----------------------------------------------------------------
  mpsc_state_t state_r;
  mpsc_state_t state_nxt;
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;

  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    if (clk_en_i) begin
      unique case (state_r)
        ST_RUN: begin
          if (wake) begin
            state_nxt = ST_RUN;
          end else if (deep_go) begin
            state_nxt = ST_SR_ENTER;
          end else if (light_go) begin
            state_nxt = ST_SUSPEND;
            mode_nxt = suspend_mode_of(sw_req_i.suspend_mode);
          end
        end
        ST_SUSPEND: begin
          if (wake) begin
            state_nxt = ST_RUN;
          end else if (deep_go) begin
            state_nxt = ST_SR_ENTER;
          end
        end
        ST_SR_ENTER: begin
          if (wake) begin
            state_nxt = ST_RUN;
          end else if (self_refresh_ack_i) begin
            state_nxt = ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (!supply_s) begin
            state_nxt = ST_LOST;
          end else if (wake) begin
            state_nxt = ST_RUN;
          end
        end
        ST_LOST: begin
          // Held in core reset until the main supply returns, then reboots
          if (supply_s) begin
            state_nxt = ST_RUN;
          end
        end
        default: begin
          state_nxt = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_RUN;
      mode_r <= CPU_WAIT;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  mpsc_outreg u_outreg (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .state_i(state_r),
    .suspend_mode_i(mode_r),
    .supply_good_i(supply_s),
    .reset_line_n_i(rst_line_s),
    .status_o(status_o),
    .module_reset_n_o(module_reset_n_o)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_run_clocks_on: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_RUN) |=>
      (status_o.osc_en == OSC_ALL_ON && status_o.core_clk_en && status_o.periph_clk_en))
    else $error("run state without all clocks enabled");

  a_run_supplies_on: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_RUN) |=>
      (status_o.supplies_active && status_o.board_state == BOARD_RUN))
    else $error("run state without supplies reported active");

  a_wake_to_run: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && wake && state_r inside {ST_SUSPEND, ST_SR_ENTER}) |=> state_r == ST_RUN)
    else $error("wake event did not return to run");

  a_standby_wake: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_STANDBY && supply_s && wake) |=> state_r == ST_RUN)
    else $error("standby ignored a wake event");

  a_reset_line_wake: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && !system_reset_line_n_i && state_r == ST_SUSPEND)
      ##1 (clk_en_i && !system_reset_line_n_i)[*2] |=> state_r == ST_RUN)
    else $error("reset line did not wake the module");

  a_suspend_entry: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_RUN && light_go && !deep_go && !wake)
      |=> (state_r == ST_SUSPEND) ##1 (status_o.board_state == BOARD_SUSPEND))
    else $error("suspend request not taken");

  a_suspend_low_mode: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_SUSPEND) |=>
      (status_o.cpu_mode != CPU_RUN && !status_o.core_clk_en))
    else $error("suspend left the processor in run mode");

  a_suspend_context: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_SUSPEND) |=>
      (status_o.supplies_active && !status_o.context_lost &&
       module_reset_n_o == $past(rst_line_s)))
    else $error("suspend lost context or supplies");

  a_standby_stop: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_STANDBY) |=> status_o.cpu_mode == CPU_STOP)
    else $error("standby without processor stop mode");

  a_standby_clocks_off: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_STANDBY) |=>
      (status_o.osc_en == OSC_ALL_OFF && !status_o.core_clk_en && !status_o.periph_clk_en))
    else $error("a clock runs in standby");

  a_supply_loss: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_STANDBY && !supply_s)
      |=> (state_r == ST_LOST) ##1 (!module_reset_n_o && status_o.context_lost))
    else $error("supply loss in standby did not force reboot");

  a_lost_no_wake: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (state_r == ST_LOST && !supply_s) |=> state_r == ST_LOST)
    else $error("woke to run without main supply");

  a_self_refresh: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (state_r != ST_STANDBY) ##1 (state_r == ST_STANDBY)
      |-> $past(state_r) == ST_SR_ENTER && $past(self_refresh_ack_i))
    else $error("standby entered without self-refresh");

  a_reset_follow: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r != ST_LOST) |=> module_reset_n_o == $past(rst_line_s))
    else $error("core reset does not follow the reset line");

  a_standby_prio: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_RUN && light_go && deep_go && !wake) |=> state_r == ST_SR_ENTER)
    else $error("suspend won over standby");

  a_freeze_state_hold: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !clk_en_i |=> ($stable(state_r) && $stable(status_o) && $stable(module_reset_n_o)))
    else $error("state moved while clock enable low");

  a_lost_core_reset: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_LOST) |=> !module_reset_n_o)
    else $error("core reset released while context lost");

  a_suspend_stay: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_SUSPEND && !wake && !deep_go) |=> state_r == ST_SUSPEND)
    else $error("suspend left without wake or standby request");

  a_standby_refresh: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_STANDBY) |=> status_o.self_refresh_req)
    else $error("self-refresh dropped in standby");

  a_run_no_lost: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (clk_en_i && state_r == ST_RUN) |=>
      (!status_o.self_refresh_req && !status_o.context_lost))
    else $error("run state reports refresh or lost context");

endmodule : mpsc_ctrl

//--- tb/mpsc_board.sv
// Purpose: Baseboard model driving the sleep request, reset and supply lines
// Assumes: Request and reset lines have pull-ups, so a released line reads high
// Notes: Calls come from the bench just after a rising clock edge
`timescale 1ns/1ps

module mpsc_board (
  input wire logic sys_clk_i,
  output logic system_reset_line_n_o,
  output logic light_sleep_request_n_o,
  output logic deep_sleep_request_n_o,
  output logic main_supply_good_o
);

  initial begin
    system_reset_line_n_o = 1'b1;
    light_sleep_request_n_o = 1'b1;
    deep_sleep_request_n_o = 1'b1;
    main_supply_good_o = 1'b1;
  end

  // ----------------------------------------------------------------
  // Line control
  // ----------------------------------------------------------------
  // Drive low or release to the pull-up level; reset low wakes the module
  task automatic set_lines(input logic rst_n, input logic light_n, input logic deep_n);
    system_reset_line_n_o = rst_n;
    light_sleep_request_n_o = light_n;
    deep_sleep_request_n_o = deep_n;
  endtask : set_lines

  // Remove or restore the main supply
  task automatic set_supply(input logic good);
    main_supply_good_o = good;
  endtask : set_supply

endmodule : mpsc_board

//--- tb/mpsc_ctrl_tb_top.sv
// Purpose: Self-checking bench for the module power-state controller
// Assumes: Bench drives inputs 2 ns after each rising edge
// Notes: Memory self-refresh acknowledge is driven by the bench
`timescale 1ns/1ps

module mpsc_ctrl_tb_top;
  import mpsc_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic rst_line_n;
  logic light_n;
  logic deep_n;
  logic supply_good;
  logic [IRQ_W-1:0] irq_pend = '0;
  logic [IRQ_W-1:0] irq_en = '0;
  mpsc_sw_req_t sw_req = '0;
  logic sr_ack = 1'b0;
  mpsc_status_t status;
  logic core_rst_n;
  int err_total = 0;
  int comparisons = 0;

  always #12.5 clk = ~clk;

  mpsc_board u_mpsc_board (
    .sys_clk_i(clk),
    .system_reset_line_n_o(rst_line_n),
    .light_sleep_request_n_o(light_n),
    .deep_sleep_request_n_o(deep_n),
    .main_supply_good_o(supply_good)
  );

  mpsc_ctrl u_mpsc_ctrl (
    .sys_clk_i(clk),
    .reset_n_i(rst_n),
    .clk_en_i(clk_en),
    .system_reset_line_n_i(rst_line_n),
    .light_sleep_request_n_i(light_n),
    .deep_sleep_request_n_i(deep_n),
    .main_supply_good_i(supply_good),
    .irq_pending_i(irq_pend),
    .irq_enable_i(irq_en),
    .sw_req_i(sw_req),
    .self_refresh_ack_i(sr_ack),
    .status_o(status),
    .module_reset_n_o(core_rst_n)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step

  // Wait on board state (0), self-refresh request (1) or core reset (2)
  task automatic wait_for(input int sel, input logic [1:0] v, input int max);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < max && !hit; i++) begin
      step(1);
      case (sel)
        0: hit = (status.board_state === v);
        1: hit = (status.self_refresh_req === v[0]);
        default: hit = (core_rst_n === v[0]);
      endcase
    end
    comparisons++;
    if (!hit) begin
      err_total++;
      $display("[FAIL] %0t wait %0d ran out", $time, sel);
      conclude();
    end
  endtask : wait_for

  task automatic sw_pulse(input logic susp, input logic stby, input logic [1:0] mode);
    sw_req = '{suspend: susp, standby: stby, suspend_mode: mode};
    step(1);
    sw_req = '0;
  endtask : sw_pulse

  task automatic irq_wake(input logic on);
    irq_pend = on ? 8'h10 : 8'h00;
    irq_en = on ? 8'h10 : 8'h00;
  endtask : irq_wake

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(status === STATUS_RESET, "run values after reset");
    wait_for(2, 2'h1, 6);
  endtask : t_reset

  task automatic t_clk_freeze();
    clk_en = 1'b0;
    sw_pulse(1'b1, 1'b0, CPU_DOZE);
    step(3);
    chk(status.board_state === BOARD_RUN, "suspend taken while frozen");
    clk_en = 1'b1;
    sw_pulse(1'b1, 1'b0, CPU_DOZE);
    wait_for(0, BOARD_SUSPEND, 4);
    clk_en = 1'b0;
    irq_wake(1'b1);
    step(4);
    chk(status.board_state === BOARD_SUSPEND, "wake taken while frozen");
    clk_en = 1'b1;
    wait_for(0, BOARD_RUN, 4);
    irq_wake(1'b0);
    step(1);
  endtask : t_clk_freeze

  task automatic t_sw_suspend();
    logic [1:0] exp;
    for (int m = 0; m < 4; m++) begin
      exp = (m == 0) ? CPU_WAIT : 2'(m);
      sw_pulse(1'b1, 1'b0, 2'(m));
      wait_for(0, BOARD_SUSPEND, 4);
      chk(status.cpu_mode === exp, "suspend mode");
      chk(status.supplies_active === 1'b1, "supplies in suspend");
      chk(status.osc_en === (exp == CPU_STOP ? OSC_MAIN_ONLY : OSC_ALL_ON), "suspend osc");
      chk(status.periph_clk_en === (exp == CPU_WAIT), "suspend periph clock");
      chk(status.core_clk_en === 1'b0, "suspend core clock");
      chk(status.context_lost === 1'b0 && core_rst_n === 1'b1, "context kept");
      irq_pend = 8'h10;
      step(4);
      chk(status.board_state === BOARD_SUSPEND, "masked irq woke");
      irq_en = 8'h10;
      wait_for(0, BOARD_RUN, 4);
      step(1);
      chk(status === STATUS_RESET, "run values after wake");
      irq_wake(1'b0);
    end
  endtask : t_sw_suspend

  task automatic t_pin_suspend_reset();
    u_mpsc_board.set_lines(1'b1, 1'b0, 1'b1);
    step(4);
    u_mpsc_board.set_lines(1'b1, 1'b1, 1'b1);
    wait_for(0, BOARD_SUSPEND, 4);
    u_mpsc_board.set_lines(1'b0, 1'b1, 1'b1);
    step(5);
    chk(core_rst_n === 1'b0, "core reset low");
    chk(status.board_state === BOARD_RUN, "reset line wake");
    step(10);
    chk(core_rst_n === 1'b0, "core reset held");
    u_mpsc_board.set_lines(1'b1, 1'b1, 1'b1);
    wait_for(2, 2'h1, 4);
  endtask : t_pin_suspend_reset

  task automatic t_pin_standby();
    u_mpsc_board.set_lines(1'b1, 1'b0, 1'b0);
    step(4);
    u_mpsc_board.set_lines(1'b1, 1'b1, 1'b1);
    wait_for(1, 2'h1, 4);
    chk(status.board_state !== BOARD_SUSPEND, "suspend won");
    step(3);
    chk(status.board_state !== BOARD_STANDBY, "standby before refresh");
    sr_ack = 1'b1;
    wait_for(0, BOARD_STANDBY, 4);
    chk(status.cpu_mode === CPU_STOP && status.self_refresh_req === 1'b1, "standby mode");
    chk(status.osc_en === OSC_ALL_OFF && status.core_clk_en === 1'b0 &&
        status.periph_clk_en === 1'b0, "clocks in standby");
    irq_wake(1'b1);
    wait_for(0, BOARD_RUN, 4);
    irq_wake(1'b0);
    sr_ack = 1'b0;
    step(1);
    chk(status === STATUS_RESET, "run after standby");
  endtask : t_pin_standby

  task automatic t_supply_loss();
    sw_pulse(1'b0, 1'b1, 2'h0);
    wait_for(1, 2'h1, 4);
    sr_ack = 1'b1;
    wait_for(0, BOARD_STANDBY, 4);
    u_mpsc_board.set_supply(1'b0);
    wait_for(2, 2'h0, 6);
    chk(status.context_lost === 1'b1 && status.supplies_active === 1'b0, "context lost");
    irq_wake(1'b1);
    step(4);
    chk(core_rst_n === 1'b0, "wake after supply loss");
    irq_wake(1'b0);
    sr_ack = 1'b0;
    u_mpsc_board.set_supply(1'b1);
    wait_for(0, BOARD_RUN, 6);
    wait_for(2, 2'h1, 4);
  endtask : t_supply_loss

  initial begin
    #500000;
    err_total++;
    $display("[FAIL] %0t run timed out", $time);
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk);
    #2;
    rst_n = 1'b1;
    t_reset();
    t_clk_freeze();
    t_sw_suspend();
    t_pin_suspend_reset();
    t_pin_standby();
    t_supply_loss();
    conclude();
  end

endmodule : mpsc_ctrl_tb_top
